//--- verilog/int_status_pkg.sv
// Constants for the interrupt status collector
package int_status_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_INT_STATUS  = 8'h58;
  localparam logic [7:0] ADDR_INT_ENABLE  = 8'h5C;
  localparam logic [7:0] ADDR_BYTE_TEST   = 8'h64;
  localparam logic [7:0] ADDR_FIFO_LEVELS = 8'h68;
  localparam logic [7:0] ADDR_DROP_COUNT  = 8'hA0;
  localparam logic [7:0] ADDR_POWER_CTRL  = 8'hB8;

  // Status bit positions
  localparam int BIT_SOFT_IRQ       = 31;
  localparam int BIT_TX_HALTED      = 25;
  localparam int BIT_RX_HALTED      = 24;
  localparam int BIT_DROP_MIDPOINT  = 23;
  localparam int BIT_BUFFER_LOADED  = 21;
  localparam int BIT_COMPLETION     = 20;
  localparam int BIT_TIMER_WRAP     = 19;
  localparam int BIT_TRANSCEIVER    = 18;
  localparam int BIT_POWER_EVENT    = 17;
  localparam int BIT_TX_STAT_OVFL   = 16;
  localparam int BIT_OVERSIZE       = 15;
  localparam int BIT_RX_ERROR       = 14;
  localparam int BIT_TX_ERROR       = 13;
  localparam int BIT_TX_DATA_OVRUN  = 10;
  localparam int BIT_TX_SPACE_AVAIL = 9;
  localparam int BIT_TX_STAT_FULL   = 8;
  localparam int BIT_TX_STAT_LEVEL  = 7;
  localparam int BIT_FRAME_DROPPED  = 6;
  localparam int BIT_RX_STAT_FULL   = 4;
  localparam int BIT_RX_STAT_LEVEL  = 3;
  localparam int BIT_PIN_EVENT_LO   = 0;

  // Implemented bits; reserved positions read zero and ignore writes
  localparam logic [31:0] STATUS_IMPL_MASK = 32'h83BFE7DF;
  // Bits software may clear by writing one (transceiver bit excluded)
  localparam logic [31:0] STATUS_W1C_MASK  = 32'h83BBE7DF;

  // Field layout of the FIFO level register and the power control sleep bit
  localparam int TX_SPACE_LVL_LSB = 24;
  localparam int TX_STAT_LVL_LSB  = 16;
  localparam int RX_STAT_LVL_LSB  = 0;
  localparam int POWER_SLEEP_BIT  = 0;
  // Threshold fields of the FIFO level register; the middle byte reads zero
  localparam logic [31:0] LEVELS_IMPL_MASK = 32'hFFFF00FF;

  // Reset and constant values
  localparam logic [31:0] STATUS_RESET      = 32'h00000000;
  localparam logic [31:0] ENABLE_RESET      = 32'h00000000;
  localparam logic [31:0] FIFO_LEVELS_RESET = 32'h48000000;
  localparam logic [31:0] DROP_COUNT_RESET  = 32'h00000000;
  localparam logic [31:0] BYTE_TEST_VALUE   = 32'h87654321;
  localparam logic [31:0] DROP_MIDPOINT_OLD = 32'h7FFFFFFF;

  typedef enum logic {
    BUS_IDLE,
    BUS_READY
  } bus_state_type;

endpackage

//--- verilog/interrupt_status_collector.sv
// Interrupt status register with APB access and event latching
//
// Contract
// - Writing one clears a latched status bit; zero leaves it; transceiver bit excepted.
// - Soft irq flag sets when soft trigger enable rises; write one clears it.
// - Transmit halted flag sets when stop is requested and transmitter has halted.
// - Receive halted flag sets when the receive engine reaches halted state.
// - Midpoint flag sets when drop counter steps from 7FFFFFFF to 80000000.
// - Buffer loaded flag sets when a notify-marked buffer is fully loaded.
// - Completion flag sets when programmed receive transfer count has been moved out.
// - Timer wrap flag sets when the timer counts through zero to FFFF.
// - Transceiver bit mirrors the transceiver event; host writes never change it.
// - Power event flag sets on matching event regardless of wake output; write clears.
// - No hold-off interval delays or suppresses the power event interrupt.
// - Overflow flag sets on a push into a full transmit status FIFO.
// - Oversize flag sets when a frame longer than 2048 bytes arrives.
// - Bit 14 sets on receive error; bit 13 sets on transmit error.
// - Data overrun flag sets on a write into the full transmit data FIFO.
// - Space flag sets while free transmit space exceeds the programmed threshold.
// - Bit 8 sets when transmit status FIFO full, bit 4 for receive.
// - Bit 7 sets when transmit status fill exceeds the programmed level.
// - Bit 6 sets each time an incoming frame is dropped.
// - Bit 3 sets when receive status fill exceeds the programmed level.
// - Bits 2..0 latch events from the three general-purpose pins.
// - Status bits latch regardless of the enable mask.
// - Master line asserts when any latched bit has its enable set.
`timescale 1ns/1ps
`default_nettype none

module interrupt_status_collector
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tx_stop_request,
  input  wire logic        tx_halted,
  input  wire logic        rx_halted,
  input  wire logic        frame_dropped,
  input  wire logic        buffer_loaded,
  input  wire logic        buffer_notify,
  input  wire logic        rx_count_done,
  input  wire logic        timer_wrap,
  input  wire logic        transceiver_event,
  input  wire logic        power_event,
  input  wire logic        tx_status_push,
  input  wire logic        tx_status_full,
  input  wire logic        rx_status_full,
  input  wire logic [7:0]  tx_status_used,
  input  wire logic [7:0]  rx_status_used,
  input  wire logic [7:0]  tx_free_blocks,
  input  wire logic        tx_data_write,
  input  wire logic        tx_data_full,
  input  wire logic        oversize_frame,
  input  wire logic        rx_error,
  input  wire logic        tx_error,
  input  wire logic [2:0]  pin_event,
  output logic             master_irq,
  output logic             power_irq,
  output logic             low_power
);

  typedef struct packed {
    int_status_pkg::bus_state_type bus;
    logic [31:0]                   rdata;
    logic                          ready;
    logic                          err;
    logic [31:0]                   status;
    logic [31:0]                   enable;
    logic [31:0]                   levels;
    logic [31:0]                   drops;
    logic                          sleep;
    logic                          tx_stop_seen;
    logic                          rx_halt_seen;
    logic                          irq;
    logic                          pwr_irq;
  } state_type;

  state_type state_q;
  state_type state_d;

  // True when a measured value is above its programmed field
  function automatic logic above_level
  (
    input logic [7:0] value,
    input logic [7:0] level
  );
    above_level = value > level;
  endfunction

  // Level register keeps only its three threshold fields
  function automatic logic [31:0] level_fields
  (
    input logic [31:0] value
  );
    level_fields = value & int_status_pkg::LEVELS_IMPL_MASK;
  endfunction

  // Register lane merge under the APB byte strobes
  function automatic logic [31:0] merge_lanes
  (
    input logic [31:0] old_value,
    input logic [31:0] new_value,
    input logic [3:0]  lanes
  );
    logic [31:0] result;
    result = old_value;
    for (int i = 0; i < 4; i++)
    begin
      if (lanes[i])
      begin
        result[i*8 +: 8] = new_value[i*8 +: 8];
      end
    end
    merge_lanes = result;
  endfunction

  // Offsets that answer without a slave error
  function automatic logic mapped
  (
    input logic [7:0] addr
  );
    case (addr)
      int_status_pkg::ADDR_INT_STATUS,
      int_status_pkg::ADDR_INT_ENABLE,
      int_status_pkg::ADDR_BYTE_TEST,
      int_status_pkg::ADDR_FIFO_LEVELS,
      int_status_pkg::ADDR_DROP_COUNT,
      int_status_pkg::ADDR_POWER_CTRL:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  endfunction

  logic [7:0]  addr_lo;
  logic        upper_zero;
  logic        setup_phase;
  logic        write_commit;
  logic [31:0] set_bits;
  logic [31:0] clr_bits;
  logic [31:0] wmask;
  logic [31:0] next_enable;

  assign addr_lo    = paddr[7:0];
  assign upper_zero = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'h0);

  always_comb
  begin
    state_d      = state_q;
    setup_phase  = psel && !penable;
    write_commit = 1'b0;
    set_bits     = 32'h00000000;
    clr_bits     = 32'h00000000;
    wmask        = 32'h00000000;
    next_enable  = state_q.enable;

    // APB slave: data prepared in setup, ready on first access edge
    case (state_q.bus)
      int_status_pkg::BUS_IDLE:
      begin
        state_d.ready = 1'b0;
        state_d.err   = 1'b0;
        if (setup_phase)
        begin
          state_d.bus   = int_status_pkg::BUS_READY;
          state_d.ready = 1'b1;
          state_d.err   = !(upper_zero && mapped(addr_lo));
          state_d.rdata = 32'h00000000;
          if (!pwrite && upper_zero)
          begin
            case (addr_lo)
              int_status_pkg::ADDR_INT_STATUS:
                state_d.rdata = state_q.status
                                & int_status_pkg::STATUS_IMPL_MASK;
              int_status_pkg::ADDR_INT_ENABLE:
                state_d.rdata = state_q.enable
                                & int_status_pkg::STATUS_IMPL_MASK;
              int_status_pkg::ADDR_BYTE_TEST:
                state_d.rdata = int_status_pkg::BYTE_TEST_VALUE;
              int_status_pkg::ADDR_FIFO_LEVELS:
                state_d.rdata = level_fields(state_q.levels);
              int_status_pkg::ADDR_DROP_COUNT:
                state_d.rdata = state_q.drops;
              int_status_pkg::ADDR_POWER_CTRL:
                state_d.rdata = {31'h00000000, state_q.sleep};
              default:
                state_d.rdata = 32'h00000000;
            endcase
          end
        end
      end
      int_status_pkg::BUS_READY:
      begin
        if (psel && penable)
        begin
          state_d.bus   = int_status_pkg::BUS_IDLE;
          state_d.ready = 1'b0;
          state_d.err   = 1'b0;
          write_commit  = pwrite && !state_q.err;
        end
        else if (!psel)
        begin
          // Master walked away mid-transfer; withdraw the answer
          state_d.bus   = int_status_pkg::BUS_IDLE;
          state_d.ready = 1'b0;
          state_d.err   = 1'b0;
        end
      end
      default:
      begin
        state_d.bus   = int_status_pkg::BUS_IDLE;
        state_d.ready = 1'b0;
        state_d.err   = 1'b0;
      end
    endcase

    // Register writes take effect on the completing access edge
    if (write_commit)
    begin
      wmask = merge_lanes(32'h00000000, 32'hFFFFFFFF, pstrb);
      case (addr_lo)
        int_status_pkg::ADDR_INT_STATUS:
          clr_bits = pwdata & wmask
                     & int_status_pkg::STATUS_W1C_MASK;
        int_status_pkg::ADDR_INT_ENABLE:
          next_enable = merge_lanes(state_q.enable, pwdata, pstrb)
                        & int_status_pkg::STATUS_IMPL_MASK;
        int_status_pkg::ADDR_BYTE_TEST:
          state_d.sleep = 1'b0;
        int_status_pkg::ADDR_FIFO_LEVELS:
          state_d.levels = level_fields(
            merge_lanes(state_q.levels, pwdata, pstrb));
        int_status_pkg::ADDR_POWER_CTRL:
          if (pstrb[0] && pwdata[int_status_pkg::POWER_SLEEP_BIT])
          begin
            state_d.sleep = 1'b1;
          end
        default:
        begin
        end
      endcase
    end
    state_d.enable = next_enable;

    // Soft trigger enable rising raises the soft flag
    set_bits[int_status_pkg::BIT_SOFT_IRQ] =
      next_enable[int_status_pkg::BIT_SOFT_IRQ]
      && !state_q.enable[int_status_pkg::BIT_SOFT_IRQ];

    state_d.tx_stop_seen = tx_stop_request && tx_halted;
    set_bits[int_status_pkg::BIT_TX_HALTED] =
      tx_stop_request && tx_halted && !state_q.tx_stop_seen;

    state_d.rx_halt_seen = rx_halted;
    set_bits[int_status_pkg::BIT_RX_HALTED] =
      rx_halted && !state_q.rx_halt_seen;

    if (frame_dropped)
    begin
      state_d.drops = state_q.drops + 32'h00000001;
    end
    set_bits[int_status_pkg::BIT_DROP_MIDPOINT] = frame_dropped
      && (state_q.drops == int_status_pkg::DROP_MIDPOINT_OLD);
    set_bits[int_status_pkg::BIT_FRAME_DROPPED] = frame_dropped;

    set_bits[int_status_pkg::BIT_BUFFER_LOADED] =
      buffer_loaded && buffer_notify;
    set_bits[int_status_pkg::BIT_COMPLETION] = rx_count_done;
    set_bits[int_status_pkg::BIT_TIMER_WRAP] = timer_wrap;
    set_bits[int_status_pkg::BIT_POWER_EVENT] = power_event;
    set_bits[int_status_pkg::BIT_TX_STAT_OVFL] =
      tx_status_push && tx_status_full;
    set_bits[int_status_pkg::BIT_OVERSIZE] = oversize_frame;
    set_bits[int_status_pkg::BIT_RX_ERROR] = rx_error;
    set_bits[int_status_pkg::BIT_TX_ERROR] = tx_error;
    set_bits[int_status_pkg::BIT_TX_DATA_OVRUN] =
      tx_data_write && tx_data_full;
    set_bits[int_status_pkg::BIT_TX_SPACE_AVAIL] = above_level(
      tx_free_blocks,
      state_q.levels[int_status_pkg::TX_SPACE_LVL_LSB +: 8]);
    set_bits[int_status_pkg::BIT_TX_STAT_FULL] = tx_status_full;
    set_bits[int_status_pkg::BIT_RX_STAT_FULL] = rx_status_full;
    set_bits[int_status_pkg::BIT_TX_STAT_LEVEL] = above_level(
      tx_status_used,
      state_q.levels[int_status_pkg::TX_STAT_LVL_LSB +: 8]);
    set_bits[int_status_pkg::BIT_RX_STAT_LEVEL] = above_level(
      rx_status_used,
      state_q.levels[int_status_pkg::RX_STAT_LVL_LSB +: 8]);
    set_bits[int_status_pkg::BIT_PIN_EVENT_LO +: 3] = pin_event;

    // Set beats clear; mask never gates latching
    state_d.status = ((state_q.status & ~clr_bits) | set_bits)
                     & int_status_pkg::STATUS_IMPL_MASK;
    // Transceiver bit only follows its source
    state_d.status[int_status_pkg::BIT_TRANSCEIVER] =
      transceiver_event;

    state_d.irq = |(state_d.status & state_d.enable);
    // Power interrupt path bypasses any hold-off timing
    state_d.pwr_irq = state_d.status[int_status_pkg::BIT_POWER_EVENT]
      && state_d.enable[int_status_pkg::BIT_POWER_EVENT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q.bus          <= int_status_pkg::BUS_IDLE;
      state_q.rdata        <= 32'h00000000;
      state_q.ready        <= 1'b0;
      state_q.err          <= 1'b0;
      state_q.status       <= int_status_pkg::STATUS_RESET;
      state_q.enable       <= int_status_pkg::ENABLE_RESET;
      state_q.levels       <= int_status_pkg::FIFO_LEVELS_RESET;
      state_q.drops        <= int_status_pkg::DROP_COUNT_RESET;
      state_q.sleep        <= 1'b0;
      state_q.tx_stop_seen <= 1'b0;
      state_q.rx_halt_seen <= 1'b0;
      state_q.irq          <= 1'b0;
      state_q.pwr_irq      <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign prdata     = state_q.rdata;
  assign pready     = state_q.ready;
  assign pslverr    = state_q.err;
  assign master_irq = state_q.irq;
  assign power_irq  = state_q.pwr_irq;
  assign low_power  = state_q.sleep;

endmodule

`default_nettype wire

//--- verif/interrupt_status_collector_properties.sv
// Concurrent checks on the status collector ports
`timescale 1ns/1ps
`default_nettype none
module interrupt_status_collector_properties
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        transceiver_event,
  input wire logic        low_power
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_commit;
    psel && penable && pready;
  endsequence
  property p_answer;
    s_setup |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("no ready after setup");
  property p_single;
    pready |=> !pready;
  endproperty
  a_single: assert property (p_single) else $error("ready held too long");
  property p_idle;
    !psel |=> !pready;
  endproperty
  a_idle: assert property (p_idle) else $error("ready without select");
  property p_misalign;
    s_setup ##0 (paddr[1:0] != 2'h0) |=> pready && pslverr;
  endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned accepted");
  property p_err_data;
    pready && pslverr |-> prdata == 32'h0;
  endproperty
  a_err_data: assert property (p_err_data) else $error("error with data");
  property p_reserved;
    s_setup ##0 (paddr == 32'h58 && !pwrite)
      |=> (prdata & ~int_status_pkg::STATUS_IMPL_MASK) == 32'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved set");
  property p_mirror;
    s_setup ##0 (paddr == 32'h58 && !pwrite && $stable(transceiver_event))
      |=> prdata[18] == $past(transceiver_event, 2);
  endproperty
  a_mirror: assert property (p_mirror) else $error("bit 18 wrong");
  property p_wake;
    s_commit ##0 (pwrite && paddr == 32'h64) |=> !low_power;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on write");
  property p_stay_asleep;
    low_power && !(psel && pwrite && paddr == 32'h64) |=> low_power;
  endproperty
  a_stay_asleep: assert property (p_stay_asleep) else $error("woke");
endmodule
bind interrupt_status_collector interrupt_status_collector_properties
  interrupt_status_collector_properties_inst
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .transceiver_event(transceiver_event),
  .low_power(low_power)
);
`default_nettype wire

//--- verif/host_bus_model.sv
// Host side APB master model
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
(
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  end
  // Call right after a rising edge; returns one edge after release
  task automatic xfer(input logic w, input logic [31:0] a, d,
                      output logic [31:0] r, output logic e);
    logic rdy;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer and its data are taken at the rising edge where pready is high
    do
    begin
      @(posedge pclk);
      rdy = pready;
      r = prdata;
      e = pslverr;
    end while (rdy !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show no stale value
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

//--- verif/tb_interrupt_status_collector.sv
// Self-checking bench for the status collector
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin \
  $display("BAD %s exp %h got %h", n, e, s); fail_count++; end end
module tb_interrupt_status_collector;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [22:0] ev;
  logic        trx, err, master_irq, power_irq, low_power;
  int          fail_count, checked, i;
  // Event input patterns and the status bits each must latch
  logic [22:0] pat [19] = '{23'h3, 23'h1, 23'h4, 23'h8, 23'h30, 23'h10,
    23'h40, 23'h80, 23'h100, 23'h600, 23'h800, 23'h3000, 23'h1000,
    23'h4000, 23'h8000, 23'h10000, 23'hE0000, 23'h100000, 23'h200000};
  logic [31:0] msk [19] = '{32'h02000000, 32'h0, 32'h01000000, 32'h40,
    32'h00200000, 32'h0, 32'h00100000, 32'h00080000, 32'h00020000,
    32'h00010100, 32'h10, 32'h400, 32'h0, 32'h8000, 32'h4000, 32'h2000,
    32'h7, 32'h200, 32'h80};
  host_bus_model host_bus_model_inst (.pclk(pclk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  interrupt_status_collector interrupt_status_collector_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_stop_request(ev[0]),
    .tx_halted(ev[1]), .rx_halted(ev[2]), .frame_dropped(ev[3]),
    .buffer_loaded(ev[4]), .buffer_notify(ev[5]), .rx_count_done(ev[6]),
    .timer_wrap(ev[7]), .transceiver_event(trx), .power_event(ev[8]),
    .tx_status_push(ev[9]), .tx_status_full(ev[10]),
    .rx_status_full(ev[11]), .tx_status_used(ev[21] ? 8'h01 : 8'h00),
    .rx_status_used(ev[22] ? 8'h01 : 8'h00),
    .tx_free_blocks(ev[20] ? 8'hFF : 8'h00), .tx_data_write(ev[12]),
    .tx_data_full(ev[13]), .oversize_frame(ev[14]), .rx_error(ev[15]),
    .tx_error(ev[16]), .pin_event(ev[19:17]), .master_irq(master_irq),
    .power_irq(power_irq), .low_power(low_power));
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task summarize;
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #40000;
    fail_count++;
    summarize();
  end
  task wr(input logic [31:0] a, d);
    host_bus_model_inst.xfer(1'b1, a, d, rd, err);
  endtask
  task rchk(input string n, input logic [31:0] a, e);
    host_bus_model_inst.xfer(1'b0, a, 32'h0, rd, err);
    `CHK(n, e, rd)
  endtask
  task pulse(input logic [22:0] p);
    ev <= p;
    @(posedge pclk);
    ev <= '0;
    @(posedge pclk);
  endtask
  initial
  begin
    presetn = 1'b0;
    ev = '0;
    trx = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("status", 32'h58, 32'h0);
    rchk("enable", 32'h5C, 32'h0);
    rchk("levels", 32'h68, 32'h48000000);
    rchk("byte test", 32'h64, 32'h87654321);
    for (i = 0; i < 19; i++)
    begin
      pulse(pat[i]);
      rchk("event", 32'h58, msk[i]);
      wr(32'h58, msk[i]);
      rchk("cleared", 32'h58, 32'h0);
    end
    rchk("drops", 32'hA0, 32'h1);
    pulse(23'h40C800);
    rchk("multi", 32'h58, 32'h0000C018);
    pulse(23'hE0000);
    wr(32'h58, 32'h0000C019);
    rchk("partial", 32'h58, 32'h6);
    wr(32'h58, 32'h6);
    host_bus_model_inst.xfer(1'b0, 32'h5A, 32'h0, rd, err);
    `CHK("misaligned", 1'b1, err)
    host_bus_model_inst.xfer(1'b0, 32'hF0, 32'h0, rd, err);
    `CHK("unmapped", 1'b1, err)
    trx <= 1'b1;
    repeat (3) @(posedge pclk);
    wr(32'h58, 32'hFFFFFFFF);
    rchk("mirror", 32'h58, 32'h00040000);
    trx <= 1'b0;
    repeat (3) @(posedge pclk);
    rchk("mirror off", 32'h58, 32'h0);
    wr(32'h5C, 32'h80000000);
    rchk("soft", 32'h58, 32'h80000000);
    wr(32'h58, 32'h80000000);
    rchk("soft clear", 32'h58, 32'h0);
    wr(32'h5C, 32'h00004000);
    // One-cycle error pulse lands on the clearing write's access edge
    fork
      wr(32'h58, 32'h4000);
      begin
        @(posedge pclk);
        ev <= 23'h8000;
        @(posedge pclk);
        ev <= '0;
      end
    join
    `CHK("master", 1'b1, master_irq)
    rchk("coincide", 32'h58, 32'h4000);
    wr(32'h58, 32'h4000);
    `CHK("master off", 1'b0, master_irq)
    wr(32'h5C, 32'h00020000);
    wr(32'hB8, 32'h1);
    `CHK("sleep", 1'b1, low_power)
    pulse(23'h100);
    rchk("power", 32'h58, 32'h00020000);
    `CHK("power irq", 1'b1, power_irq)
    `CHK("still asleep", 1'b1, low_power)
    wr(32'h64, 32'h0);
    `CHK("woken", 1'b0, low_power)
    wr(32'h58, 32'h00020000);
    `CHK("power off", 1'b0, power_irq)
    summarize();
  end
endmodule
`default_nettype wire
